// File: pkg/lmccr_consts.svh
`ifndef LMCCR_CONSTS_SVH
`define LMCCR_CONSTS_SVH

`define LMCCR_CMD_WR_CFG0 16'haa00
`define LMCCR_CMD_WR_CFG1 16'haa01
`define LMCCR_CMD_RD_CFG0 16'haa60
`define LMCCR_CMD_RD_CFG1 16'haa61

`define LMCCR_CFG0_RESET 48'h2000_e000_0107
`define LMCCR_CFG1_RESET 48'h00e0_0094_a400
`define LMCCR_CFG1_WMASK 48'h7fff_ffff_ffff

`define LMCCR_POWER_SAVE_ENABLE_BIT 12
`define LMCCR_EPS_HI 14
`define LMCCR_EPS_LO 13
`define LMCCR_OLR_BIT 15
`define LMCCR_SCAN_HI 21
`define LMCCR_SCAN_LO 16
`define LMCCR_SUBP_HI 24
`define LMCCR_SUBP_LO 22
`define LMCCR_RANGE_BIT 28
`define LMCCR_MUL_HI 32
`define LMCCR_MUL_LO 29
`define LMCCR_DLY_R_HI 38
`define LMCCR_DLY_R_LO 36
`define LMCCR_DLY_G_HI 41
`define LMCCR_DLY_G_LO 39
`define LMCCR_DLY_B_HI 44
`define LMCCR_DLY_B_LO 42
`define LMCCR_SLR_BIT 47
`define LMCCR_SEG_HI 9
`define LMCCR_SEG_LO 0

`define LMCCR_SEG_CODE_LONG 10'h3ff
`define LMCCR_SEG_LONG 11'h400
`define LMCCR_SEG_SHORT 11'h080
`endif

// File: pkg/lmccr_pkg.sv
package lmccr_pkg;
	typedef enum logic [1:0]
	{
		LMCCR_EPS_OFF,
		LMCCR_EPS_QUARTER,
		LMCCR_EPS_HALF,
		LMCCR_EPS_SEVEN_EIGHTHS
	} lmccr_eps_t;

	typedef struct packed
	{
		logic valid;
		logic [15:0] id;
		logic [47:0] data;
	} lmccr_cmd_t;

	typedef struct packed
	{
		logic power_save_enable;
		lmccr_eps_t enhanced_power_save_select;
		logic open_load_removal_enable;
		logic [6:0] scan_line_count;
		logic [7:0] subperiod_count;
		logic multiplier_range_select;
		logic [4:0] multiplier_ratio;
		logic [2:0] red_group_delay;
		logic [2:0] green_group_delay;
		logic [2:0] blue_group_delay;
		logic short_led_artefact_removal_enable;
		logic [10:0] segment_clock_count;
	} lmccr_cfg_t;
endpackage

// File: design/lmccr_regs.sv
`include "lmccr_consts.svh"

module lmccr_regs
	import lmccr_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire lmccr_cmd_t i_cmd,
	input wire logic i_forward_pwm_mode,
	input wire logic [15:0] i_channel_grayscale_value,
	output logic o_read_valid,
	output logic [47:0] o_read_data,
	output lmccr_cfg_t o_cfg,
	output logic o_off_cycle_power_save
);
	logic [47:0] cfg0;
	logic [47:0] cfg1;
	logic read_valid;
	logic [47:0] read_data;

	wire logic wr0 = i_cmd.valid && (i_cmd.id == `LMCCR_CMD_WR_CFG0);
	wire logic wr1 = i_cmd.valid && (i_cmd.id == `LMCCR_CMD_WR_CFG1);
	wire logic rd0 = i_cmd.valid && (i_cmd.id == `LMCCR_CMD_RD_CFG0);
	wire logic rd1 = i_cmd.valid && (i_cmd.id == `LMCCR_CMD_RD_CFG1);
	// Reserved top bit of the second register stays zero
	wire logic [47:0] next_cfg1 = i_cmd.data & `LMCCR_CFG1_WMASK;
	wire logic [47:0] next_read_data = rd0 ? cfg0 : (rd1 ? cfg1 : read_data);

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cfg0 <= `LMCCR_CFG0_RESET;
			cfg1 <= `LMCCR_CFG1_RESET;
		end
		else
		begin
			if (wr0)
				cfg0 <= i_cmd.data;
			if (wr1)
				cfg1 <= next_cfg1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			read_valid <= 1'b0;
			read_data <= 48'h0000_0000_0000;
		end
		else
		begin
			read_valid <= rd0 || rd1;
			read_data <= next_read_data;
		end
	end

	assign o_read_valid = read_valid;
	assign o_read_data = read_data;

	wire logic [5:0] scan_field = cfg0[`LMCCR_SCAN_HI:`LMCCR_SCAN_LO];
	wire logic [2:0] subp_field = cfg0[`LMCCR_SUBP_HI:`LMCCR_SUBP_LO];
	wire logic [3:0] mul_field = cfg0[`LMCCR_MUL_HI:`LMCCR_MUL_LO];
	wire logic [9:0] seg_field = cfg1[`LMCCR_SEG_HI:`LMCCR_SEG_LO];
	wire logic [3:0] subp_units = {1'b0, subp_field} + 4'h1;
	wire logic [10:0] seg_len = (seg_field == `LMCCR_SEG_CODE_LONG) ?
		`LMCCR_SEG_LONG : `LMCCR_SEG_SHORT;
	wire lmccr_eps_t eps_mode = lmccr_eps_t'(cfg0[`LMCCR_EPS_HI:`LMCCR_EPS_LO]);

	// Off-cycle saving threshold as a fraction of the segment
	logic [10:0] eps_threshold;
	always_comb
	begin
		case (eps_mode)
			LMCCR_EPS_QUARTER: eps_threshold = seg_len >> 2;
			LMCCR_EPS_HALF: eps_threshold = seg_len >> 1;
			LMCCR_EPS_SEVEN_EIGHTHS: eps_threshold = seg_len - (seg_len >> 3);
			default: eps_threshold = 11'h000;
		endcase
	end

	assign o_off_cycle_power_save = (eps_mode != LMCCR_EPS_OFF) &&
		(i_channel_grayscale_value <= {5'h00, eps_threshold});

	assign o_cfg.power_save_enable = cfg0[`LMCCR_POWER_SAVE_ENABLE_BIT];
	assign o_cfg.enhanced_power_save_select = eps_mode;
	assign o_cfg.open_load_removal_enable = cfg0[`LMCCR_OLR_BIT];
	assign o_cfg.scan_line_count = {1'b0, scan_field} + 7'h01;
	assign o_cfg.subperiod_count = {subp_units, 4'h0};
	assign o_cfg.multiplier_range_select = cfg0[`LMCCR_RANGE_BIT];
	assign o_cfg.multiplier_ratio = {1'b0, mul_field} + 5'h01;
	// Group delays collapse to zero outside forward PWM mode
	wire logic [2:0] dly_r_field = cfg0[`LMCCR_DLY_R_HI:`LMCCR_DLY_R_LO];
	wire logic [2:0] dly_g_field = cfg0[`LMCCR_DLY_G_HI:`LMCCR_DLY_G_LO];
	wire logic [2:0] dly_b_field = cfg0[`LMCCR_DLY_B_HI:`LMCCR_DLY_B_LO];
	function automatic logic [2:0] gate_delay(input logic forward_mode, input logic [2:0] field);
		gate_delay = forward_mode ? field : 3'h0;
	endfunction
	assign o_cfg.red_group_delay = gate_delay(i_forward_pwm_mode, dly_r_field);
	assign o_cfg.green_group_delay = gate_delay(i_forward_pwm_mode, dly_g_field);
	assign o_cfg.blue_group_delay = gate_delay(i_forward_pwm_mode, dly_b_field);
	assign o_cfg.short_led_artefact_removal_enable = cfg0[`LMCCR_SLR_BIT];
	assign o_cfg.segment_clock_count = seg_len;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_wr0;
		i_cmd.valid && (i_cmd.id == `LMCCR_CMD_WR_CFG0);
	endsequence
	sequence s_rd0;
		i_cmd.valid && (i_cmd.id == `LMCCR_CMD_RD_CFG0);
	endsequence
	sequence s_wr1;
		i_cmd.valid && (i_cmd.id == `LMCCR_CMD_WR_CFG1);
	endsequence
	sequence s_rd1;
		i_cmd.valid && (i_cmd.id == `LMCCR_CMD_RD_CFG1);
	endsequence

	ps_enable_follow_a: assert property (s_wr0 |=>
		o_cfg.power_save_enable == $past(i_cmd.data[`LMCCR_POWER_SAVE_ENABLE_BIT]))
		else $error("power save bit not taken");
	ps_enable_hold_a: assert property (!wr0 |=>
		$stable(o_cfg.power_save_enable))
		else $error("power save bit moved without write");
	olr_enable_follow_a: assert property (s_wr0 |=>
		o_cfg.open_load_removal_enable == $past(i_cmd.data[`LMCCR_OLR_BIT]))
		else $error("open load removal bit not taken");
	olr_enable_hold_a: assert property (!wr0 |=>
		$stable(o_cfg.open_load_removal_enable))
		else $error("open load removal bit moved without write");

	read_back_cfg0_a: assert property (s_wr0 ##1 s_rd0 |=>
		o_read_valid && o_read_data == $past(i_cmd.data, 2))
		else $error("cfg0 read back mismatch");
	read_back_cfg1_a: assert property (s_wr1 ##1 s_rd1 |=>
		o_read_valid && o_read_data == ($past(i_cmd.data, 2) & `LMCCR_CFG1_WMASK))
		else $error("cfg1 read back mismatch");

	eps_threshold_a: assert property (eps_mode == LMCCR_EPS_QUARTER &&
		seg_len == `LMCCR_SEG_SHORT && i_channel_grayscale_value == 16'h0021 |-> !o_off_cycle_power_save)
		else $error("quarter threshold wrong");
	eps_select_follow_a: assert property (s_wr0 |=>
		2'(eps_mode) == $past(i_cmd.data[`LMCCR_EPS_HI:`LMCCR_EPS_LO]))
		else $error("power save select not taken");
	eps_off_quiet_a: assert property (eps_mode == LMCCR_EPS_OFF |->
		!o_off_cycle_power_save)
		else $error("off cycle saving while disabled");
	eps_half_edge_a: assert property (eps_mode == LMCCR_EPS_HALF &&
		seg_len == `LMCCR_SEG_SHORT && i_channel_grayscale_value == 16'h0040 |-> o_off_cycle_power_save)
		else $error("half threshold wrong");
	eps_seven_long_a: assert property (eps_mode == LMCCR_EPS_SEVEN_EIGHTHS &&
		seg_len == `LMCCR_SEG_LONG && i_channel_grayscale_value == 16'h0381 |-> !o_off_cycle_power_save)
		else $error("seven eighths threshold too high");
	eps_seven_edge_a: assert property (eps_mode == LMCCR_EPS_SEVEN_EIGHTHS &&
		seg_len == `LMCCR_SEG_LONG && i_channel_grayscale_value == 16'h0380 |-> o_off_cycle_power_save)
		else $error("seven eighths threshold too low");

	scan_count_a: assert property (o_cfg.scan_line_count == 7'(scan_field) + 7'h01 &&
		o_cfg.scan_line_count != 7'h00)
		else $error("scan line count wrong");
	scan_follow_a: assert property (s_wr0 |=>
		o_cfg.scan_line_count == 7'($past(i_cmd.data[`LMCCR_SCAN_HI:`LMCCR_SCAN_LO])) + 7'h01)
		else $error("scan line field not taken");
	scan_max_a: assert property (scan_field == 6'h3f |->
		o_cfg.scan_line_count == 7'h40)
		else $error("scan line maximum wrong");
	subp_count_a: assert property (subp_field == 3'h7 |->
		o_cfg.subperiod_count == 8'h80)
		else $error("subperiod count wrong");
	subp_min_a: assert property (subp_field == 3'h0 |->
		o_cfg.subperiod_count == 8'h10)
		else $error("subperiod minimum wrong");
	subp_follow_a: assert property (s_wr0 |=>
		o_cfg.subperiod_count == {4'($past(i_cmd.data[`LMCCR_SUBP_HI:`LMCCR_SUBP_LO])) + 4'h1, 4'h0})
		else $error("subperiod field not taken");

	range_select_a: assert property (s_wr0 |=>
		o_cfg.multiplier_range_select == $past(i_cmd.data[`LMCCR_RANGE_BIT]))
		else $error("range select not taken");
	range_hold_a: assert property (!wr0 |=>
		$stable(o_cfg.multiplier_range_select))
		else $error("range select moved without write");
	mul_ratio_a: assert property (s_wr0 |=>
		o_cfg.multiplier_ratio == 5'($past(i_cmd.data[`LMCCR_MUL_HI:`LMCCR_MUL_LO])) + 5'h01)
		else $error("multiplier ratio wrong");
	mul_max_a: assert property (mul_field == 4'hf |->
		o_cfg.multiplier_ratio == 5'h10)
		else $error("multiplier maximum wrong");
	mul_hold_a: assert property (!wr0 |=>
		$stable(o_cfg.multiplier_ratio))
		else $error("multiplier ratio moved without write");

	red_delay_gate_a: assert property (!i_forward_pwm_mode |->
		o_cfg.red_group_delay == 3'h0)
		else $error("red delay outside forward mode");
	red_delay_fwd_a: assert property (i_forward_pwm_mode |->
		o_cfg.red_group_delay == cfg0[`LMCCR_DLY_R_HI:`LMCCR_DLY_R_LO])
		else $error("red delay wrong");
	green_delay_gate_a: assert property (i_forward_pwm_mode |->
		o_cfg.green_group_delay == cfg0[`LMCCR_DLY_G_HI:`LMCCR_DLY_G_LO])
		else $error("green delay wrong");
	green_delay_off_a: assert property (!i_forward_pwm_mode |->
		o_cfg.green_group_delay == 3'h0)
		else $error("green delay outside forward mode");
	blue_delay_gate_a: assert property (i_forward_pwm_mode |->
		o_cfg.blue_group_delay == cfg0[`LMCCR_DLY_B_HI:`LMCCR_DLY_B_LO])
		else $error("blue delay wrong");
	blue_delay_off_a: assert property (!i_forward_pwm_mode |->
		o_cfg.blue_group_delay == 3'h0)
		else $error("blue delay outside forward mode");

	slr_enable_follow_a: assert property (s_wr0 |=>
		o_cfg.short_led_artefact_removal_enable == $past(i_cmd.data[`LMCCR_SLR_BIT]))
		else $error("short led removal bit not taken");
	slr_enable_hold_a: assert property (!wr0 |=>
		$stable(o_cfg.short_led_artefact_removal_enable))
		else $error("short led removal bit moved without write");

	segment_clock_count_a: assert property (o_cfg.segment_clock_count ==
		((seg_field == `LMCCR_SEG_CODE_LONG) ? `LMCCR_SEG_LONG : `LMCCR_SEG_SHORT))
		else $error("segment length wrong");
	segment_clock_count_follow_a: assert property (s_wr1 |=> o_cfg.segment_clock_count ==
		(($past(i_cmd.data[`LMCCR_SEG_HI:`LMCCR_SEG_LO]) == 10'h3ff) ? 11'h400 : 11'h080))
		else $error("segment length not taken");
endmodule

// File: dv/lmccr_ctrl_model.sv
module lmccr_ctrl_model
	import lmccr_pkg::*;
(
	input wire logic i_ref_clk,
	output lmccr_cmd_t o_cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_cmd = '0;
	// Idle cycle, then one command pulse
	task automatic send(input logic [15:0] id, input logic [47:0] d);
		@(posedge i_ref_clk);
		#1 o_cmd = '{1'b1, id, d};
		@(posedge i_ref_clk);
		#1 o_cmd.valid = 1'b0;
	endtask
endmodule

// File: dv/tb_top.sv
`include "lmccr_consts.svh"
module tb_top
	import lmccr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic fwd = 1'b1;
	logic [15:0] gs = 16'h0;
	lmccr_cmd_t cmd;
	logic rv;
	logic [47:0] rdat;
	lmccr_cfg_t c;
	logic ops;
	int n_fail = 0;
	int n_tests = 0;
	localparam logic [15:0] TH [4] = '{16'h0, 16'h20, 16'h40, 16'h70};
	localparam logic [9:0] SC [3] = '{10'h3ff, 10'h07f, 10'h005};
	localparam logic [10:0] SL [3] = '{11'h400, 11'h080, 11'h080};
	always #50 i_ref_clk = ~i_ref_clk;
	lmccr_ctrl_model ctrl (.i_ref_clk(i_ref_clk), .o_cmd(cmd));
	lmccr_regs DUT (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_cmd(cmd),
		.i_forward_pwm_mode(fwd), .i_channel_grayscale_value(gs),
		.o_read_valid(rv), .o_read_data(rdat), .o_cfg(c), .o_off_cycle_power_save(ops));
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read pulse lasts exactly one cycle
	task automatic rd(input logic [15:0] id, input logic [47:0] exp);
		ctrl.send(id, 48'h0);
		chk(48'(rv), 48'h1);
		chk(rdat, exp);
		@(posedge i_ref_clk);
		#1 chk(rv, 48'h0);
	endtask
	// Reserved and line charge fields kept at reset values
	function automatic logic [47:0] mk0(input logic f, input logic [1:0] e,
		input logic [5:0] s, input logic [2:0] p, input logic [3:0] m, input logic [2:0] d);
		mk0 = 48'h2000_0000_0107 | 48'(f) * 48'h8000_1000_9000 | 48'(e) << 13 | 48'(s) << 16
			| 48'(p) << 22 | 48'(m) << 29 | 48'(d) << 36 | {45'h0, ~d} << 39
			| {45'h0, 3'(d + 3'h1)} << 42;
	endfunction
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge i_ref_clk);
		#1 i_reset_n = 1'b1;
		rd(`LMCCR_CMD_RD_CFG0, `LMCCR_CFG0_RESET);
		rd(`LMCCR_CMD_RD_CFG1, `LMCCR_CFG1_RESET);
		chk({c.scan_line_count, c.subperiod_count, c.multiplier_ratio}, 20'h02208);
		$display("test reset done");
		ctrl.send(`LMCCR_CMD_WR_CFG0, mk0(1'b1, 2'h3, 6'h3f, 3'h7, 4'hf, 3'h5));
		chk({c.power_save_enable, c.enhanced_power_save_select, c.open_load_removal_enable,
			c.multiplier_range_select, c.short_led_artefact_removal_enable}, 48'h3f);
		chk({c.scan_line_count, c.subperiod_count, c.multiplier_ratio}, {7'h40, 8'h80, 5'h10});
		chk({c.red_group_delay, c.green_group_delay, c.blue_group_delay}, 9'h156);
		ctrl.send(16'haa02, 48'h0);
		chk(rv, 48'h0);
		rd(`LMCCR_CMD_RD_CFG0, mk0(1'b1, 2'h3, 6'h3f, 3'h7, 4'hf, 3'h5));
		fwd = 1'b0;
		ctrl.send(`LMCCR_CMD_WR_CFG0, mk0(1'b0, 2'h0, 6'h0, 3'h0, 4'h0, 3'h2));
		chk({c.power_save_enable, c.open_load_removal_enable, c.multiplier_range_select,
			c.short_led_artefact_removal_enable}, 48'h0);
		chk({c.scan_line_count, c.subperiod_count, c.multiplier_ratio}, 20'h02201);
		chk({c.red_group_delay, c.green_group_delay, c.blue_group_delay}, 48'h0);
		fwd = 1'b1;
		#1 chk({c.red_group_delay, c.green_group_delay, c.blue_group_delay}, 9'h0ab);
		$display("test config fields done");
		for (int i = 0; i < 3; i++)
		begin
			ctrl.send(`LMCCR_CMD_WR_CFG1, `LMCCR_CFG1_RESET | 48'h8000_0000_0000 | 48'(SC[i]));
			chk(c.segment_clock_count, SL[i]);
		end
		rd(`LMCCR_CMD_RD_CFG1, `LMCCR_CFG1_RESET | 48'h5);
		$display("test segment length done");
		for (int i = 0; i < 4; i++)
		begin
			ctrl.send(`LMCCR_CMD_WR_CFG0, mk0(1'b0, 2'(i), 6'h0, 3'h0, 4'h7, 3'h0));
			gs = TH[i];
			#1 chk(ops, 48'(i != 0));
			gs = TH[i] + 16'h1;
			#1 chk(ops, 48'h0);
		end
		$display("test power save threshold done");
		finish_test();
	end
endmodule
